// ===== hdl/swc_cfg.svh
// constants for the stepping wiper control block
`ifndef SWC_CFG_SVH
`define SWC_CFG_SVH

// register offsets
`define SWC_ADDR_SETTING 8'h00
`define SWC_ADDR_STEP 8'h01
`define SWC_ADDR_MODE 8'h02
`define SWC_ADDR_SOFT_POR 8'hAA

// reset and factory values
`define SWC_RST_SETTING 8'h40
`define SWC_RST_STEP 8'h00
`define SWC_RST_MODE 8'h00
`define SWC_RST_TAP 7'h40

// field positions
`define SWC_MODE_VOLATILE_BIT 7
`define SWC_SOFT_POR_BIT 7

// serial bus device address
`define SWC_SLAVE_ADDR 7'h50

// tap positions and stepping figures
`define SWC_POS_MAX 7'h7F
`define SWC_CENTER_POS 7'h40
`define SWC_INIT_BASE_PULSES 10'h200
`define SWC_PERIOD_BASE 9'h020

// timing
`define SWC_CLK_PERIOD_NS 4
`define SWC_NV_WRITE_TIME_NS 10000000
`define SWC_NV_WRITE_CYCLES (`SWC_NV_WRITE_TIME_NS / `SWC_CLK_PERIOD_NS)

`endif

// ===== hdl/swc_pkg.sv
// types shared by the stepping wiper control block
package swc_pkg;

  typedef struct packed {
    logic reserved;
    logic [1:0] period_sel;
    logic [4:0] span;
  } swc_step_ctrl_type;

  typedef struct packed {
    logic [6:0] wiper;
    logic [6:0] centered;
  } swc_taps_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RECV = 3'b001,
    ST_ACK = 3'b010,
    ST_SEND = 3'b011,
    ST_RACK = 3'b100
  } swc_bus_state_type;

endpackage

// ===== hdl/swc_top.sv
// stepping wiper control: serial register file, nonvolatile copies and stepping engine
`timescale 1ns/100ps
`include "swc_cfg.svh"
// Notes on behaviour
// - wiper setting is an unsigned tap position 0 to 127
// - stored initial setting leaves reset at 40h
// - power-up copies stored initial setting into the wiper setting
// - write to 00h reaches stored copy only when write mode bit 7 is clear
// - reads of 00h always return the volatile wiper setting
// - write mode is volatile, resets to 00h, changing it touches no setting
// - step span is step control bits 4:0; zero disables stepping
// - step control bits 6:5 select 32, 64, 128 or 256 pulses per step
// - while stepping runs, tap outputs update on the falling edge of the step pulse
// - wiper setting clamped between span and 127 minus span
// - reset or writes to 00h-02h suspend stepping for 512 plus half-period pulses
// - while suspended wiper follows setting, centered sits at 40h, offset cleared
// - stepping resumes with offset zero, direction up
// - each pulse decrements countdown; the pulse that finds it at one moves offset and reloads countdown
// - up direction raises offset, saturating at span
// - down direction lowers offset, saturating at minus span
// - wiper tap is setting plus offset; centered tap is 64 plus offset
// - direction turns at plus span and at minus span
// - span and pulses-per-step are kept nonvolatile and bus writable
// - bit 7 of AAh recalls 00h-02h power-up values, then self-clears
// - a written wiper value applies as soon as its byte is acknowledged
// - nonvolatile write starts at stop; repeated start drops it
// - device address not acknowledged while a nonvolatile write runs
module swc_top #(
  parameter logic [6:0] SLAVE_ADDR = `SWC_SLAVE_ADDR,
  parameter int NV_WRITE_CYCLES = `SWC_NV_WRITE_CYCLES
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // serial bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // step pulse pin
  input wire logic step_pulse_in,
  // tap selection and status
  output swc_pkg::swc_taps_type taps,
  output logic nv_busy
);

  if (NV_WRITE_CYCLES < 1 || NV_WRITE_CYCLES > 16777215) begin : g_bad_cycles
    $error("NV_WRITE_CYCLES must lie between 1 and 2**24-1");
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: bit 0 clock, bit 1 data, bit 2 step pulse

  logic [2:0] pin_raw;
  logic [2:0] meta_q;
  logic [2:0] sync_q;
  logic [2:0] prev_q;
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic pulse_fall;

  assign pin_raw = {step_pulse_in, sda_in, scl_in};

  // idle-high pins, so reset to ones to avoid a false edge at release
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      meta_q <= 3'h7;
      sync_q <= 3'h7;
      prev_q <= 3'h7;
    end else begin
      meta_q <= pin_raw;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign scl_s = sync_q[0];
  assign sda_s = sync_q[1];
  assign scl_rise = scl_s & ~prev_q[0];
  assign scl_fall = ~scl_s & prev_q[0];
  assign start_det = scl_s & prev_q[0] & prev_q[1] & ~sda_s;
  assign stop_det = scl_s & prev_q[0] & ~prev_q[1] & sda_s;
  assign pulse_fall = prev_q[2] & ~sync_q[2];

  ////////////////////////////////////////////////////////////////////////////
  // serial bus slave

  swc_pkg::swc_bus_state_type state_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic [1:0] byte_idx_q;
  logic rw_q;
  logic [7:0] ptr_q;
  logic sda_oe_q;
  logic sda_out_q;
  logic wr_stb_q;
  logic [7:0] wr_addr_q;
  logic [7:0] wr_data_q;
  logic [7:0] rd_data;
  logic nv_busy_q;

  logic [7:0] wiper_q;
  logic [7:0] step_q;
  logic [7:0] mode_q;

  always_comb begin
    case (ptr_q)
      `SWC_ADDR_SETTING: rd_data = wiper_q;
      `SWC_ADDR_STEP: rd_data = step_q;
      `SWC_ADDR_MODE: rd_data = mode_q;
      default: rd_data = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state_q <= swc_pkg::ST_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      byte_idx_q <= 2'h0;
      rw_q <= 1'b0;
      ptr_q <= 8'h00;
      sda_oe_q <= 1'b0;
      wr_stb_q <= 1'b0;
      wr_addr_q <= 8'h00;
      wr_data_q <= 8'h00;
    end else begin
      wr_stb_q <= 1'b0;
      if (start_det) begin
        state_q <= swc_pkg::ST_RECV;
        bit_cnt_q <= 4'h0;
        byte_idx_q <= 2'h0;
        sda_oe_q <= 1'b0;
      end else if (stop_det) begin
        state_q <= swc_pkg::ST_IDLE;
        sda_oe_q <= 1'b0;
      end else begin
        case (state_q)
          swc_pkg::ST_RECV: begin
            if (scl_rise) begin
              shift_q <= {shift_q[6:0], sda_s};
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end else if (scl_fall && bit_cnt_q == 4'h8) begin
              bit_cnt_q <= 4'h0;
              if (byte_idx_q == 2'h0) begin
                if (shift_q[7:1] == SLAVE_ADDR && !nv_busy_q) begin
                  rw_q <= shift_q[0];
                  sda_oe_q <= 1'b1;
                  state_q <= swc_pkg::ST_ACK;
                end else begin
                  // not for us: stay deaf until the next start
                  state_q <= swc_pkg::ST_IDLE;
                end
              end else begin
                sda_oe_q <= 1'b1;
                state_q <= swc_pkg::ST_ACK;
                if (byte_idx_q == 2'h1) begin
                  ptr_q <= shift_q;
                end else begin
                  // strobe at the acknowledge, well before the stop
                  wr_stb_q <= 1'b1;
                  wr_addr_q <= ptr_q;
                  wr_data_q <= shift_q;
                  ptr_q <= ptr_q + 8'h01;
                end
              end
            end
          end
          swc_pkg::ST_ACK: begin
            if (scl_fall) begin
              byte_idx_q <= (byte_idx_q == 2'h2) ? 2'h2 : byte_idx_q + 2'h1;
              if (rw_q) begin
                state_q <= swc_pkg::ST_SEND;
                shift_q <= rd_data;
                sda_oe_q <= ~rd_data[7];
                ptr_q <= ptr_q + 8'h01;
              end else begin
                state_q <= swc_pkg::ST_RECV;
                sda_oe_q <= 1'b0;
              end
            end
          end
          swc_pkg::ST_SEND: begin
            if (scl_fall) begin
              if (bit_cnt_q == 4'h7) begin
                bit_cnt_q <= 4'h0;
                sda_oe_q <= 1'b0;
                state_q <= swc_pkg::ST_RACK;
              end else begin
                bit_cnt_q <= bit_cnt_q + 4'h1;
                shift_q <= {shift_q[6:0], 1'b0};
                sda_oe_q <= ~shift_q[6];
              end
            end
          end
          swc_pkg::ST_RACK: begin
            if (scl_rise && sda_s) begin
              state_q <= swc_pkg::ST_IDLE;
            end else if (scl_fall) begin
              state_q <= swc_pkg::ST_SEND;
              shift_q <= rd_data;
              sda_oe_q <= ~rd_data[7];
              ptr_q <= ptr_q + 8'h01;
            end
          end
          default: begin
            state_q <= swc_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  // open drain: the data line is only ever pulled low
  always_ff @(posedge sys_clk) begin
    sda_out_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // volatile registers

  logic power_up_q;
  logic recall;
  logic [7:0] nv_setting_q;
  logic [7:0] nv_step_q;

  assign recall = power_up_q | (wr_stb_q && wr_addr_q == `SWC_ADDR_SOFT_POR
                  && wr_data_q[`SWC_SOFT_POR_BIT]);

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      power_up_q <= 1'b1;
      wiper_q <= `SWC_RST_SETTING;
      step_q <= `SWC_RST_STEP;
      mode_q <= `SWC_RST_MODE;
    end else begin
      power_up_q <= 1'b0;
      if (recall) begin
        wiper_q <= nv_setting_q;
        step_q <= nv_step_q;
        mode_q <= `SWC_RST_MODE;
      end else if (wr_stb_q) begin
        case (wr_addr_q)
          `SWC_ADDR_SETTING: wiper_q <= wr_data_q;
          `SWC_ADDR_STEP: step_q <= wr_data_q;
          `SWC_ADDR_MODE: mode_q <= wr_data_q;
          default: begin
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // nonvolatile copies and write timing

  logic pend_setting_q;
  logic pend_step_q;
  logic [7:0] shadow_setting_q;
  logic [7:0] shadow_step_q;
  logic [23:0] busy_cnt_q;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      nv_setting_q <= `SWC_RST_SETTING;
      nv_step_q <= `SWC_RST_STEP;
      pend_setting_q <= 1'b0;
      pend_step_q <= 1'b0;
      shadow_setting_q <= 8'h00;
      shadow_step_q <= 8'h00;
      busy_cnt_q <= 24'h000000;
      nv_busy_q <= 1'b0;
    end else begin
      if (nv_busy_q) begin
        busy_cnt_q <= busy_cnt_q - 24'h000001;
        if (busy_cnt_q == 24'h000001) begin
          nv_busy_q <= 1'b0;
        end
      end
      if (stop_det && (pend_setting_q || pend_step_q)) begin
        if (pend_setting_q) begin
          nv_setting_q <= shadow_setting_q;
        end
        if (pend_step_q) begin
          nv_step_q <= shadow_step_q;
        end
        pend_setting_q <= 1'b0;
        pend_step_q <= 1'b0;
        busy_cnt_q <= 24'(NV_WRITE_CYCLES);
        nv_busy_q <= 1'b1;
      end else if (start_det) begin
        // repeated start: keep the volatile change, skip the slow write
        pend_setting_q <= 1'b0;
        pend_step_q <= 1'b0;
      end else if (wr_stb_q) begin
        if (wr_addr_q == `SWC_ADDR_SETTING && !mode_q[`SWC_MODE_VOLATILE_BIT]) begin
          pend_setting_q <= 1'b1;
          shadow_setting_q <= wr_data_q;
        end
        if (wr_addr_q == `SWC_ADDR_STEP) begin
          pend_step_q <= 1'b1;
          shadow_step_q <= wr_data_q;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stepping engine

  swc_pkg::swc_step_ctrl_type sc;
  logic restart;
  logic [8:0] period;
  logic [9:0] init_target;
  logic [6:0] lo;
  logic [6:0] hi;
  logic [6:0] wr_c;
  logic signed [6:0] span_ext;
  logic signed [6:0] off_ext;
  logic signed [6:0] off_up;
  logic signed [6:0] off_dn;
  logic signed [6:0] off_new;
  logic run_q;
  logic dir_up_q;
  logic [9:0] init_cnt_q;
  logic [8:0] countdown_q;
  logic signed [5:0] off_q;
  swc_pkg::swc_taps_type taps_q;

  assign sc = swc_pkg::swc_step_ctrl_type'(step_q);
  assign restart = recall || (wr_stb_q && (wr_addr_q == `SWC_ADDR_SETTING
                   || wr_addr_q == `SWC_ADDR_STEP || wr_addr_q == `SWC_ADDR_MODE));
  assign period = `SWC_PERIOD_BASE << sc.period_sel;
  assign init_target = `SWC_INIT_BASE_PULSES + {2'b00, period[8:1]};

  // a span of one is left to the controller to avoid; nothing guards it
  assign lo = {2'b00, sc.span};
  assign hi = `SWC_POS_MAX - lo;
  assign wr_c = (wiper_q[6:0] < lo) ? lo : ((wiper_q[6:0] > hi) ? hi : wiper_q[6:0]);

  assign span_ext = {2'b00, sc.span};
  assign off_ext = {off_q[5], off_q};
  assign off_up = (off_ext + 7'sh01 > span_ext) ? span_ext : off_ext + 7'sh01;
  assign off_dn = (off_ext - 7'sh01 < -span_ext) ? -span_ext : off_ext - 7'sh01;
  assign off_new = dir_up_q ? off_up : off_dn;

  function automatic swc_pkg::swc_taps_type taps_at(input logic [6:0] base, input logic signed [5:0] off);
    swc_pkg::swc_taps_type t;
    logic [7:0] offx;
    offx = {{2{off[5]}}, off};
    t.wiper = 7'({1'b0, base} + offx);
    t.centered = 7'({1'b0, `SWC_CENTER_POS} + offx);
    return t;
  endfunction

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      run_q <= 1'b0;
      init_cnt_q <= 10'h000;
      off_q <= 6'sh00;
      dir_up_q <= 1'b1;
      countdown_q <= `SWC_PERIOD_BASE;
    end else if (restart) begin
      run_q <= 1'b0;
      init_cnt_q <= 10'h000;
      off_q <= 6'sh00;
      dir_up_q <= 1'b1;
      countdown_q <= period;
    end else if (pulse_fall) begin
      if (!run_q) begin
        if (init_cnt_q + 10'h001 == init_target) begin
          run_q <= 1'b1;
          countdown_q <= period;
        end else begin
          init_cnt_q <= init_cnt_q + 10'h001;
        end
        off_q <= 6'sh00;
        dir_up_q <= 1'b1;
      end else if (sc.span != 5'h00) begin
        if (countdown_q == 9'h001) begin
          countdown_q <= period;
          off_q <= off_new[5:0];
          if (off_new == span_ext) begin
            dir_up_q <= 1'b0;
          end else if (off_new == -span_ext) begin
            dir_up_q <= 1'b1;
          end
        end else begin
          countdown_q <= countdown_q - 9'h001;
        end
      end
    end
  end

  // suspended or disabled: follow the setting every cycle, so a write shows at once
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      taps_q <= '{wiper: `SWC_RST_TAP, centered: `SWC_CENTER_POS};
    end else if (!run_q || sc.span == 5'h00) begin
      taps_q <= taps_at(wr_c, 6'sh00);
    end else if (pulse_fall) begin
      if (countdown_q == 9'h001) begin
        taps_q <= taps_at(wr_c, off_new[5:0]);
      end else begin
        taps_q <= taps_at(wr_c, off_q);
      end
    end
  end

  assign taps = taps_q;
  assign sda_oe = sda_oe_q;
  assign sda_out = sda_out_q;
  assign nv_busy = nv_busy_q;

endmodule // swc_top

// ===== verification/swc_assertions.sv
// port checker for the stepping wiper control
`timescale 1ns/100ps
module swc_assertions (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // pins
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic step_pulse_in,
  // results
  input wire swc_pkg::swc_taps_type taps,
  input wire logic nv_busy
);
  logic scl_q, sda_q, sp_q;
  logic [3:0] scl_age_q, fall_age_q, sp_age_q, stop_age_q;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // saturating ages: 15 means long ago
  function automatic logic [3:0] age(input logic hit, input logic [3:0] a);
    return hit ? 4'h0 : (a == 4'hF ? a : a + 4'h1);
  endfunction
  always_ff @(posedge sys_clk) begin
    scl_q <= scl_in;
    sda_q <= sda_in;
    sp_q <= step_pulse_in;
  end
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      {scl_age_q, fall_age_q, sp_age_q, stop_age_q} <= 16'hFFFF;
    end else begin
      scl_age_q <= age(scl_q != scl_in, scl_age_q);
      fall_age_q <= age(scl_q && !scl_in, fall_age_q);
      sp_age_q <= age(sp_q && !step_pulse_in, sp_age_q);
      stop_age_q <= age(scl_in && !sda_q && sda_in, stop_age_q);
    end
  end
  ////////////////////////////////////////////////////////////
  ack_timing_a: assert property ($changed(sda_oe) |-> fall_age_q >= 4'h1 && fall_age_q <= 4'h6)
    else $error("data drive off clock fall");
  open_drain_a: assert property (sda_out == 1'b0) else $error("data driven high");
  busy_silent_a: assert property (nv_busy |-> !sda_oe) else $error("answered while busy");
  busy_stop_a: assert property ($rose(nv_busy) |-> stop_age_q <= 4'h8) else $error("store without stop");
  pulse_edge_a: assert property ($changed(taps) |-> sp_age_q <= 4'h8 || scl_age_q <= 4'hA)
    else $error("taps moved without cause");
  unit_step_a: assert property ($changed(taps.centered) && scl_age_q > 4'hA |->
    taps.centered == $past(taps.centered) + 7'h1 || taps.centered == $past(taps.centered) - 7'h1)
    else $error("offset jumped");
  same_offset_a: assert property ($changed(taps.centered) && scl_age_q > 4'hA |->
    taps.wiper - $past(taps.wiper) == taps.centered - $past(taps.centered))
    else $error("taps moved apart");
  centre_range_a: assert property (taps.centered >= 7'h21 && taps.centered <= 7'h5F)
    else $error("offset past 31");
  cover property ($rose(nv_busy));
  cover property (taps.centered == 7'h3E);
  cover property ($rose(sda_oe));
endmodule // swc_assertions
bind swc_top swc_assertions chk_u (.sys_clk(sys_clk), .nrst(nrst), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .step_pulse_in(step_pulse_in), .taps(taps), .nv_busy(nv_busy));

// ===== verification/swc_bus_model.sv
// serial bus controller and step pulse source for the wiper control bench
`timescale 1ns/100ps
module swc_bus_model (
  // clock
  input wire logic sys_clk,
  // device pull-down on the data line
  input wire logic sda_oe,
  // pins seen by the device
  output logic scl,
  output logic sda,
  output logic step_pulse
);
  logic m_low;
  // open drain with pull-up: a released line reads high
  assign sda = ~(m_low | sda_oe);
  initial begin
    m_low = 1'b0;
    scl = 1'b1;
    step_pulse = 1'b1;
  end
  task automatic hp;
    repeat (6) @(negedge sys_clk);
  endtask
  ////////////////////////////////////////////////////////////
  // also a repeated start, which drops a pending stored update
  task automatic start;
    m_low = 1'b0;
    hp();
    scl = 1'b1;
    hp();
    m_low = 1'b1;
    hp();
    scl = 1'b0;
    hp();
  endtask
  task automatic stop;
    m_low = 1'b1;
    hp();
    scl = 1'b1;
    hp();
    m_low = 1'b0;
    hp();
  endtask
  task automatic bit_xfer(input logic b, output logic r);
    m_low = ~b;
    hp();
    scl = 1'b1;
    hp();
    r = sda;
    scl = 1'b0;
    hp();
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_xfer(d[i], r);
    bit_xfer(1'b1, r);
    ack = ~r;
  endtask
  task automatic rd_byte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_xfer(1'b1, d[i]);
    bit_xfer(~more, r);
  endtask
  // step clock idles high between bursts, 64 ns period
  task automatic pulses(input int n);
    repeat (n) begin
      step_pulse = 1'b0;
      repeat (8) @(negedge sys_clk);
      step_pulse = 1'b1;
      repeat (8) @(negedge sys_clk);
    end
  endtask
endmodule // swc_bus_model

// ===== verification/tb_stepping_wiper_control.sv
// self-checking bench for the stepping wiper control
`timescale 1ns/100ps
module tb_stepping_wiper_control;
  localparam int NV_CYC = 600;
  logic sys_clk, nrst, scl, sda, sp, sda_out, sda_oe, nv_busy, ack;
  swc_pkg::swc_taps_type taps;
  logic [7:0] rd_d;
  int err_count, checks, p;
  int offs[10] = '{2, 1, 0, -1, -2, -1, 0, 1, 2, 1};
  swc_top #(.NV_WRITE_CYCLES(NV_CYC)) dut_u (.sys_clk(sys_clk), .nrst(nrst), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .step_pulse_in(sp), .taps(taps), .nv_busy(nv_busy));
  swc_bus_model bus_u (.sys_clk(sys_clk), .sda_oe(sda_oe), .scl(scl), .sda(sda), .step_pulse(sp));
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // whole run needs about 67k cycles
  initial begin
    repeat (95000) @(posedge sys_clk);
    err_count++;
    $display("FAIL %0t watchdog", $time);
    end_sim();
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] want);
    checks++;
    if (got !== want) begin
      err_count++;
      $display("FAIL %0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic chk_taps(input logic [6:0] w, input logic [6:0] c);
    checks++;
    if (taps !== {w, c}) begin
      err_count++;
      $display("FAIL %0t taps %h want %h %h", $time, taps, w, c);
    end
  endtask
  task automatic end_sim;
    if (err_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 2 * NV_CYC && nv_busy !== 1'b0; i++) @(negedge sys_clk);
    chk({7'h00, nv_busy}, 8'h00);
  endtask
  task automatic addr(input logic rw, input logic want);
    bus_u.start();
    bus_u.wr_byte({7'h50, rw}, ack);
    chk({7'h00, ack}, {7'h00, want});
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] want);
    addr(1'b0, 1'b1);
    bus_u.wr_byte(a, ack);
    addr(1'b1, 1'b1);
    bus_u.rd_byte(1'b0, rd_d);
    bus_u.stop();
    chk(rd_d, want);
  endtask
  // nv of x: the store may or may not run
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic rep, input logic nv);
    addr(1'b0, 1'b1);
    bus_u.wr_byte(a, ack);
    bus_u.wr_byte(d, ack);
    chk({7'h00, ack}, 8'h01);
    if (rep) begin
      bus_u.start();
    end else begin
      bus_u.stop();
    end
    if (nv !== 1'bx) begin
      chk({7'h00, nv_busy}, {7'h00, nv});
    end
    wait_idle();
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    err_count = 0;
    checks = 0;
    nrst = 1'b0;
    repeat (12) @(negedge sys_clk);
    nrst = 1'b1;
    repeat (4) @(negedge sys_clk);
    chk_taps(7'h40, 7'h40);
    rd(8'h00, 8'h40);
    rd(8'h01, 8'h00);
    rd(8'h02, 8'h00);
    rd(8'h10, 8'h00);
    addr(1'b0, 1'b1);
    bus_u.wr_byte(8'h00, ack);
    bus_u.wr_byte(8'h55, ack);
    chk_taps(7'h55, 7'h40);
    bus_u.stop();
    chk({7'h00, nv_busy}, 8'h01);
    addr(1'b0, 1'b0);
    bus_u.stop();
    wait_idle();
    wr(8'h02, 8'h80, 1'b0, 1'b0);
    rd(8'h00, 8'h55);
    wr(8'h00, 8'h30, 1'b0, 1'b0);
    chk_taps(7'h30, 7'h40);
    rd(8'h00, 8'h30);
    wr(8'hAA, 8'h80, 1'b0, 1'bx);
    chk_taps(7'h55, 7'h40);
    rd(8'h02, 8'h00);
    rd(8'hAA, 8'h00);
    wr(8'h00, 8'h22, 1'b1, 1'b0);
    chk_taps(7'h22, 7'h40);
    wr(8'hAA, 8'h80, 1'b0, 1'bx);
    chk_taps(7'h55, 7'h40);
    for (int s = 3; s >= 0; s--) begin
      p = 32 << s;
      wr(8'h01, {1'b0, 2'(s), 5'h02}, 1'b0, 1'b1);
      bus_u.pulses(511 + p / 2 + p);
      chk_taps(7'h55, 7'h40);
      bus_u.pulses(1);
      chk_taps(7'h56, 7'h41);
    end
    foreach (offs[i]) begin
      bus_u.pulses(32);
      chk_taps(7'(85 + offs[i]), 7'(64 + offs[i]));
    end
    wr(8'h02, 8'h80, 1'b0, 1'b0);
    wr(8'h00, 8'h7F, 1'b0, 1'b0);
    chk_taps(7'h7D, 7'h40);
    wr(8'h00, 8'h00, 1'b0, 1'b0);
    chk_taps(7'h02, 7'h40);
    wr(8'h01, 8'h00, 1'b0, 1'b1);
    bus_u.pulses(40);
    chk_taps(7'h00, 7'h40);
    end_sim();
  end
endmodule // tb_stepping_wiper_control
